/* File: bench/serial_node_model.sv */
`timescale 1ns/100ps
module serial_node_model (
    // Clock.
    input wire logic core_clk_in,
    // Pull-down request; a released line rests high through the pull-up.
    output logic line_low_out
);
    // Sends start, data LSB first and two stop periods, then leaves the line released.
    task automatic send(input logic [8:0] word, input int nbits, input int bit_clks);
        int i;
        begin
            line_low_out <= 1'b1;
            repeat (bit_clks) @(posedge core_clk_in);
            for (i = 0; i < nbits; i++) begin
                line_low_out <= ~word[i];
                repeat (bit_clks) @(posedge core_clk_in);
            end
            line_low_out <= 1'b0;
            repeat (2 * bit_clks) @(posedge core_clk_in);
        end
    endtask
    // The node starts released.
    initial line_low_out = 1'b0;
endmodule // serial_node_model

/* File: bench/uart_single_wire_receive_and_control_tb.sv */
`timescale 1ns/100ps
`include "uart_sw_map.svh"
module uart_single_wire_receive_and_control_tb;
    import uart_sw_pkg::*;
    logic core_clk_in, resetn_in, sw_mode, node_low, tx_pin_out, tx_pin_oe_n_out, shared_wire, sclk;
    wb_req_t req;
    wb_rsp_t rsp;
    logic [31:0] rd;
    int err_total, n_tests, i, k;
    logic [8:0] tx_word;
    // Frame table: check field, word, bit count, expected check error.
    logic [1:0] chk_tab [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    logic [8:0] word_tab [4] = '{9'h0A5, 9'h03C, 9'h03C, 9'h155};
    int nb_tab [4] = '{8, 9, 9, 9};
    logic pe_tab [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    // Rate table: control base, integer divider, fraction, clocks per bit.
    logic [31:0] ctl_tab [4] = '{32'h00000223, 32'h00000003, 32'h00000503, 32'h00000203};
    logic [31:0] int_tab [4] = '{32'h00000001, 32'h00000001, 32'h00000004, 32'h00000002};
    logic [31:0] frac_tab [4] = '{32'h00000002, 32'h00000000, 32'h00000000, 32'h00000000};
    int bclk_tab [4] = '{18, 16, 16, 16};
    // Open-drain wire with pull-up: any party driving low wins.
    assign shared_wire = (tx_pin_oe_n_out ? 1'b1 : tx_pin_out) & ~(sw_mode & node_low);
    uart_sw_core uut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .wb_req_in(req), .wb_rsp_out(rsp),
        .rx_pin_in(sw_mode | ~node_low), .tx_pin_in(shared_wire), .tx_pin_out(tx_pin_out),
        .tx_pin_oe_n_out(tx_pin_oe_n_out), .sync_clk_out(sclk));
    serial_node_model node (.core_clk_in(core_clk_in), .line_low_out(node_low));
    // Free-running 50 MHz clock.
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    // Prints counts and the verdict, then ends the run.
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic Wishbone cycle; read data is taken at the acknowledging edge.
    task automatic wb(input logic we, input logic [5:0] adr, input logic [31:0] dat, output logic [31:0] d);
        int n;
        begin
            req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
            n = 0;
            do begin
                @(posedge core_clk_in);
                n++;
            end while (rsp.ack !== 1'b1 && n < 20);
            if (rsp.ack !== 1'b1) begin
                err_total++;
                results();
            end else begin
                d = rsp.dat;
                req <= '0;
                @(posedge core_clk_in);
            end
        end
    endtask
    // Polls the flags until receive-done shows, under a bound.
    task automatic wait_rc;
        int n;
        begin
            rd = 32'h00000000;
            for (n = 0; n < 60 && rd[`FLAG_RC] !== 1'b1; n++) wb(1'b0, `OFS_EVENT_FLAGS, 32'h00000000, rd);
            if (rd[`FLAG_RC] !== 1'b1) begin
                err_total++;
                results();
            end
        end
    endtask
    // Main sequence.
    initial begin
        req = '0;
        sw_mode = 1'b0;
        err_total = 0;
        n_tests = 0;
        resetn_in = 1'b0;
        repeat (12) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        @(posedge core_clk_in);
        wb(1'b0, `OFS_CONTROL_ONE, 32'h00000000, rd); check(rd, 32'h00000000);
        wb(1'b0, `OFS_EVENT_FLAGS, 32'h00000000, rd); check(rd, 32'h00000001);
        wb(1'b0, 6'h3C, 32'h00000000, rd); check(rd, 32'h00000000);
        for (i = 0; i < 4; i++) begin
            wb(1'b1, `OFS_RATE_INT, int_tab[i], rd);
            wb(1'b1, `OFS_RATE_FRAC, frac_tab[i], rd);
            wb(1'b1, `OFS_FLAG_CLEAR, 32'h00000000, rd);
            wb(1'b0, `OFS_EVENT_FLAGS, 32'h00000000, rd); check(rd, 32'h00000001);
            wb(1'b1, `OFS_CONTROL_ONE, ctl_tab[i] | (32'(chk_tab[i]) << 2), rd);
            wb(1'b0, `OFS_CONTROL_ONE, 32'h00000000, rd); check(rd, ctl_tab[i] | (32'(chk_tab[i]) << 2));
            node.send(word_tab[i], nb_tab[i], bclk_tab[i]);
            wait_rc();
            check({rd[4:1], 28'h0000000}, {pe_tab[i], 1'b0, 1'b1, 1'b0, 28'h0000000});
            wb(1'b0, `OFS_RECEIVED_WORD, 32'h00000000, rd); check(rd, 32'(word_tab[i]));
            wb(1'b1, `OFS_FLAG_CLEAR, 32'hFFFFFFFB, rd);
            wb(1'b0, `OFS_EVENT_FLAGS, 32'h00000000, rd); check(rd[`FLAG_RC], 1'b0);
            check(rd[`FLAG_PE], pe_tab[i]);
        end
        sw_mode <= 1'b1;
        wb(1'b1, `OFS_CONTROL_TWO, 32'h00000002, rd);
        wb(1'b1, `OFS_CONTROL_ONE, 32'h00000203, rd);
        node.send(9'h05A, 8, 16);
        wait_rc();
        wb(1'b0, `OFS_RECEIVED_WORD, 32'h00000000, rd); check(rd, 32'h0000005A);
        sw_mode <= 1'b0;
        wb(1'b1, `OFS_CONTROL_TWO, 32'h00000000, rd);
        tx_word = 9'h0C3;
        wb(1'b1, `OFS_OUTGOING_WORD, 32'(tx_word), rd);
        for (k = 0; k < 40 && shared_wire !== 1'b0; k++) @(posedge core_clk_in);
        check(shared_wire, 1'b0);
        repeat (8) @(posedge core_clk_in);
        for (i = 0; i < 8; i++) begin
            repeat (16) @(posedge core_clk_in);
            check(shared_wire, tx_word[i]);
        end
        repeat (32) @(posedge core_clk_in);
        wb(1'b0, `OFS_EVENT_FLAGS, 32'h00000000, rd); check(rd[1:0], 2'h3);
        // Clocked mode: eight data bits, bit clock high for half of each sixteen-clock bit.
        wb(1'b1, `OFS_FLAG_CLEAR, 32'h00000000, rd);
        wb(1'b1, `OFS_CONTROL_ONE, 32'h00000241, rd);
        wb(1'b1, `OFS_OUTGOING_WORD, 32'h000000A5, rd);
        k = 0;
        for (i = 0; i < 200; i++) begin
            @(posedge core_clk_in);
            if (sclk === 1'b1) k++;
        end
        check(k, 64);
        wb(1'b0, `OFS_EVENT_FLAGS, 32'h00000000, rd); check(rd[1:0], 2'h3);
        results();
    end
endmodule // uart_single_wire_receive_and_control_tb

/* File: rtl/uart_sw_core.sv */
`timescale 1ns/100ps
`include "uart_sw_map.svh"
module uart_sw_core (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Register bus.
    input wire uart_sw_pkg::wb_req_t wb_req_in,
    output uart_sw_pkg::wb_rsp_t wb_rsp_out,
    // Serial pins; the transmit pin enable is low while driving.
    input wire logic rx_pin_in,
    input wire logic tx_pin_in,
    output logic tx_pin_out,
    output logic tx_pin_oe_n_out,
    output logic sync_clk_out
);
    import uart_sw_pkg::*;

    // Byte-lane merge for register writes.
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic [10:0] cr1_reg, cr1_next;
    logic [9:0] cr2_reg, cr2_next;
    logic [6:0] ier_reg, ier_next;
    logic [15:0] rate_int_divider_reg, rate_int_divider_next;
    logic [3:0] rate_frac_divider_reg, rate_frac_divider_next;
    logic [7:0] addr_reg, addr_next, mask_reg, mask_next;
    logic [8:0] rdr_reg, rdr_next, hold_reg, hold_next;
    logic hold_full_reg, hold_full_next;
    flags_t flags_reg, flags_next, flag_set;
    logic take, wr, icr_wr, tc_set;
    logic [25:0] acc_reg, acc_next, tick_len, acc_sum;
    logic tick;
    logic [4:0] n_os, half;
    logic rx_s1_reg, rx_s2_reg, rx_s3_reg, tx_s1_reg, tx_s2_reg, tx_s3_reg;
    logic line, line_prev, start_seen;
    rx_state_t rx_state_reg, rx_state_next;
    logic [4:0] rx_cnt_reg, rx_cnt_next;
    logic [3:0] rx_bits_reg, rx_bits_next;
    logic [8:0] rx_sh_reg, rx_sh_next;
    tx_state_t tx_state_reg, tx_state_next;
    logic [5:0] tx_cnt_reg, tx_cnt_next, stop_ticks;
    logic [3:0] tx_bits_reg, tx_bits_next;
    logic [8:0] tx_sh_reg, tx_sh_next;
    logic tx_bit_reg, tx_bit_next, sclk_reg, sclk_next;
    logic sync_mode, nine, rx_on, tx_on, single;
    logic [1:0] check, ratio;

    assign ratio = cr1_reg[`CR1_RATIO_HI:`CR1_RATIO_LO];
    assign check = cr1_reg[`CR1_CHECK_HI:`CR1_CHECK_LO];
    assign sync_mode = cr1_reg[`CR1_SYNC_MODE];
    assign nine = (check != 2'b00) && !sync_mode;
    assign rx_on = cr1_reg[`CR1_RX_ON];
    assign tx_on = cr1_reg[`CR1_TX_ON];
    assign single = cr2_reg[`CR2_SINGLE_WIRE];
    assign take = wb_req_in.cyc && wb_req_in.stb && !ack_reg;
    assign wr = take && wb_req_in.we;
    assign icr_wr = wr && (wb_req_in.adr == `OFS_FLAG_CLEAR);

    // Bus answer one cycle after the request, then registers and their write effects.
    always_comb begin
        ack_next = take;
        rdat_next = rdat_reg;
        cr1_next = cr1_reg;
        cr2_next = cr2_reg;
        ier_next = ier_reg;
        rate_int_divider_next = rate_int_divider_reg;
        rate_frac_divider_next = rate_frac_divider_reg;
        addr_next = addr_reg;
        mask_next = mask_reg;
        hold_next = hold_reg;
        hold_full_next = hold_full_reg;
        if (tx_state_reg == TX_IDLE && tx_on && hold_full_reg) begin
            hold_full_next = 1'b0;
        end
        if (take && !wb_req_in.we) begin
            case (wb_req_in.adr)
                `OFS_CONTROL_ONE: rdat_next = {21'h0, cr1_reg};
                `OFS_CONTROL_TWO: rdat_next = {22'h0, cr2_reg};
                `OFS_EVENT_ENABLE: rdat_next = {25'h0, ier_reg};
                `OFS_RATE_INT: rdat_next = {16'h0, rate_int_divider_reg};
                `OFS_RATE_FRAC: rdat_next = {28'h0, rate_frac_divider_reg};
                `OFS_EVENT_FLAGS: rdat_next = {27'h0, flags_reg, !hold_full_reg};
                `OFS_RECEIVED_WORD: rdat_next = {23'h0, rdr_reg};
                `OFS_OWN_ADDRESS: rdat_next = {24'h0, addr_reg};
                `OFS_ADDRESS_MASK: rdat_next = {24'h0, mask_reg};
                default: rdat_next = `RESET_WORD;
            endcase
        end
        if (wr) begin
            case (wb_req_in.adr)
                `OFS_CONTROL_ONE: cr1_next = 11'(wmerge({21'h0, cr1_reg}, wb_req_in.dat, wb_req_in.sel));
                `OFS_CONTROL_TWO: cr2_next = 10'(wmerge({22'h0, cr2_reg}, wb_req_in.dat, wb_req_in.sel));
                `OFS_EVENT_ENABLE: ier_next = 7'(wmerge({25'h0, ier_reg}, wb_req_in.dat, wb_req_in.sel));
                `OFS_RATE_INT: rate_int_divider_next = 16'(wmerge({16'h0, rate_int_divider_reg}, wb_req_in.dat, wb_req_in.sel));
                `OFS_RATE_FRAC: rate_frac_divider_next = 4'(wmerge({28'h0, rate_frac_divider_reg}, wb_req_in.dat, wb_req_in.sel));
                `OFS_OWN_ADDRESS: addr_next = 8'(wmerge({24'h0, addr_reg}, wb_req_in.dat, wb_req_in.sel));
                `OFS_ADDRESS_MASK: mask_next = 8'(wmerge({24'h0, mask_reg}, wb_req_in.dat, wb_req_in.sel));
                `OFS_OUTGOING_WORD: begin
                    if (!hold_full_reg) begin
                        hold_next = 9'(wmerge({23'h0, hold_reg}, wb_req_in.dat, wb_req_in.sel));
                        hold_full_next = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_reg <= 1'b0;
            rdat_reg <= `RESET_WORD;
            cr1_reg <= `RESET_CONTROL_ONE;
            cr2_reg <= 10'h000;
            ier_reg <= 7'h00;
            rate_int_divider_reg <= 16'h0000;
            rate_frac_divider_reg <= 4'h0;
            addr_reg <= 8'h00;
            mask_reg <= 8'h00;
            hold_reg <= 9'h000;
            hold_full_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            cr1_reg <= cr1_next;
            cr2_reg <= cr2_next;
            ier_reg <= ier_next;
            rate_int_divider_reg <= rate_int_divider_next;
            rate_frac_divider_reg <= rate_frac_divider_next;
            addr_reg <= addr_next;
            mask_reg <= mask_next;
            hold_reg <= hold_next;
            hold_full_reg <= hold_full_next;
        end
    end

    assign wb_rsp_out.ack = ack_reg;
    assign wb_rsp_out.dat = rdat_reg;

    // Sample tick length in 1/256 clock units and samples per bit.
    always_comb begin
        if (rate_frac_divider_reg != 4'h0 || ratio == 2'b00) begin
            tick_len = {2'h0, rate_int_divider_reg, rate_frac_divider_reg, 4'h0};
            n_os = 5'h10;
        end else if (ratio == 2'b01) begin
            tick_len = {2'h0, rate_int_divider_reg, 8'h00};
            n_os = 5'h08;
        end else if (ratio == 2'b10) begin
            tick_len = {2'h0, rate_int_divider_reg, 8'h00};
            n_os = 5'h04;
        end else begin
            tick_len = {14'h0, rate_int_divider_reg[15:4]};
            n_os = 5'h10;
        end
        half = n_os >> 1;
        acc_sum = acc_reg + `PHASE_STEP;
        tick = (tick_len != 26'h0) && (acc_sum >= tick_len);
        acc_next = tick ? acc_sum - tick_len : acc_sum;
        if (tick_len == 26'h0) begin
            acc_next = 26'h0;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            acc_reg <= 26'h0;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // Pin synchronisers; a third stage feeds the edge detector.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_s3_reg <= 1'b1;
            tx_s1_reg <= 1'b1;
            tx_s2_reg <= 1'b1;
            tx_s3_reg <= 1'b1;
        end else begin
            rx_s1_reg <= rx_pin_in;
            rx_s2_reg <= rx_s1_reg;
            rx_s3_reg <= rx_s2_reg;
            tx_s1_reg <= tx_pin_in;
            tx_s2_reg <= tx_s1_reg;
            tx_s3_reg <= tx_s2_reg;
        end
    end

    // The shared pin is sampled even during own transmission.
    assign line = single ? tx_s2_reg : rx_s2_reg;
    assign line_prev = single ? tx_s3_reg : rx_s3_reg;
    assign start_seen = cr1_reg[`CR1_START_SEL] ? !line : (line_prev && !line);

    // Receiver.
    always_comb begin
        rx_state_next = rx_state_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_bits_next = rx_bits_reg;
        rx_sh_next = rx_sh_reg;
        rdr_next = rdr_reg;
        flag_set = '0;
        case (rx_state_reg)
            RX_IDLE: begin
                rx_bits_next = 4'h0;
                if (rx_on && sync_mode) begin
                    rx_state_next = RX_DATA;
                    rx_cnt_next = half;
                end else if (rx_on && start_seen) begin
                    rx_state_next = RX_START;
                    rx_cnt_next = 5'h00;
                end
            end
            RX_START: begin
                if (tick) begin
                    if (rx_cnt_reg == half - 5'h01) begin
                        rx_cnt_next = 5'h00;
                        rx_state_next = line ? RX_IDLE : RX_DATA;
                    end else begin
                        rx_cnt_next = rx_cnt_reg + 5'h01;
                    end
                end
            end
            RX_DATA: begin
                if (tick) begin
                    if (rx_cnt_reg == n_os - 5'h01) begin
                        rx_cnt_next = 5'h00;
                        rx_sh_next = {line, rx_sh_reg[8:1]};
                        rx_bits_next = rx_bits_reg + 4'h1;
                        if (rx_bits_reg == (nine ? 4'h8 : 4'h7)) begin
                            if (sync_mode) begin
                                rx_state_next = RX_IDLE;
                                rdr_next = {1'b0, line, rx_sh_reg[8:2]};
                                flag_set.rc = 1'b1;
                            end else begin
                                rx_state_next = RX_STOP;
                            end
                        end
                    end else begin
                        rx_cnt_next = rx_cnt_reg + 5'h01;
                    end
                end
            end
            RX_STOP: begin
                if (tick) begin
                    if (rx_cnt_reg == n_os - 5'h01) begin
                        rx_state_next = RX_IDLE;
                        rdr_next = nine ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};
                        flag_set.rc = 1'b1;
                        flag_set.fe = !line;
                        flag_set.pe = check[1] && ((^rx_sh_reg) != check[0]);
                    end else begin
                        rx_cnt_next = rx_cnt_reg + 5'h01;
                    end
                end
            end
            default: rx_state_next = RX_IDLE;
        endcase
        if (!rx_on) begin
            rx_state_next = RX_IDLE;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg <= 5'h00;
            rx_bits_reg <= 4'h0;
            rx_sh_reg <= 9'h000;
            rdr_reg <= 9'h000;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_bits_reg <= rx_bits_next;
            rx_sh_reg <= rx_sh_next;
            rdr_reg <= rdr_next;
        end
    end

    // Transmitter; stop time in ticks from the stop field.
    always_comb begin
        case (cr1_reg[`CR1_STOP_HI:`CR1_STOP_LO])
            2'b01: stop_ticks = {1'b0, n_os} + {1'b0, half};
            2'b10: stop_ticks = {n_os, 1'b0};
            default: stop_ticks = {1'b0, n_os};
        endcase
        tx_state_next = tx_state_reg;
        tx_cnt_next = tx_cnt_reg;
        tx_bits_next = tx_bits_reg;
        tx_sh_next = tx_sh_reg;
        tx_bit_next = tx_bit_reg;
        sclk_next = 1'b0;
        tc_set = 1'b0;
        case (tx_state_reg)
            TX_IDLE: begin
                tx_bit_next = 1'b1;
                tx_cnt_next = 6'h00;
                tx_bits_next = 4'h0;
                if (tx_on && hold_full_reg) begin
                    tx_sh_next = {check[1] ? (^hold_reg[7:0]) ^ check[0] : hold_reg[8], hold_reg[7:0]};
                    tx_state_next = sync_mode ? TX_DATA : TX_START;
                    tx_bit_next = sync_mode ? hold_reg[0] : 1'b0;
                end
            end
            TX_START, TX_DATA: begin
                sclk_next = (tx_state_reg == TX_DATA) && sync_mode && (tx_cnt_reg >= {1'b0, half});
                if (tick) begin
                    if (tx_cnt_reg == {1'b0, n_os} - 6'h01) begin
                        tx_cnt_next = 6'h00;
                        if (tx_state_reg == TX_START) begin
                            tx_state_next = TX_DATA;
                            tx_bit_next = tx_sh_reg[0];
                        end else if (tx_bits_reg == (nine ? 4'h8 : 4'h7)) begin
                            tx_state_next = sync_mode ? TX_IDLE : TX_STOP;
                            tx_bit_next = 1'b1;
                            tc_set = sync_mode;
                        end else begin
                            tx_sh_next = {1'b0, tx_sh_reg[8:1]};
                            tx_bit_next = tx_sh_reg[1];
                            tx_bits_next = tx_bits_reg + 4'h1;
                        end
                    end else begin
                        tx_cnt_next = tx_cnt_reg + 6'h01;
                    end
                end
            end
            TX_STOP: begin
                if (tick) begin
                    if (tx_cnt_reg == stop_ticks - 6'h01) begin
                        tx_state_next = TX_IDLE;
                        tc_set = 1'b1;
                    end else begin
                        tx_cnt_next = tx_cnt_reg + 6'h01;
                    end
                end
            end
            default: tx_state_next = TX_IDLE;
        endcase
        if (!tx_on) begin
            tx_state_next = TX_IDLE;
            tx_bit_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg <= 6'h00;
            tx_bits_reg <= 4'h0;
            tx_sh_reg <= 9'h000;
            tx_bit_reg <= 1'b1;
            sclk_reg <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_bits_reg <= tx_bits_next;
            tx_sh_reg <= tx_sh_next;
            tx_bit_reg <= tx_bit_next;
            sclk_reg <= sclk_next;
        end
    end

    // Single-wire releases the pin for a one; otherwise push-pull.
    assign tx_pin_out = tx_bit_reg;
    assign tx_pin_oe_n_out = single ? tx_bit_reg : 1'b0;
    assign sync_clk_out = sclk_reg;

    // Sticky flags: a zero written clears its flag, a new event wins.
    always_comb begin
        flags_next = flags_reg;
        if (icr_wr && wb_req_in.sel[0]) begin
            flags_next = flags_reg & wb_req_in.dat[`FLAG_PE:`FLAG_TC];
        end
        flags_next = flags_next | flag_set;
        flags_next.tc = flags_next.tc | tc_set;
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Checks on the guarded behaviour.
    sequence s_clear_rc;
        icr_wr && wb_req_in.sel[0] && !wb_req_in.dat[`FLAG_RC] && !flag_set.rc;
    endsequence
    sequence s_clear_all;
        icr_wr && wb_req_in.sel[0] && wb_req_in.dat[7:0] == 8'h00 && flag_set == '0 && !tc_set;
    endsequence
    a_rc_clear_zero: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        s_clear_rc |=> !flags_reg.rc) else $error("receive-done not cleared");
    a_flags_clear_all: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        s_clear_all |=> flags_reg == '0) else $error("flags not all cleared");
    a_rc_after_stop: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (rx_state_reg == RX_STOP && rx_state_next == RX_IDLE && rx_on) |=> flags_reg.rc) else $error("no rc");
    a_frac_forces_16: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        rate_frac_divider_reg != 4'h0 |-> n_os == 5'h10 && tick_len == {2'h0, rate_int_divider_reg, rate_frac_divider_reg, 4'h0})
        else $error("fraction did not force sixteen samples");
    a_rx_off_idle: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !rx_on |=> rx_state_reg == RX_IDLE) else $error("receiver ran while off");
    a_edge_start: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (rx_state_reg == RX_IDLE && rx_on && !sync_mode && !cr1_reg[`CR1_START_SEL] && !line_prev)
        |=> rx_state_reg == RX_IDLE) else $error("start without falling edge");
    a_open_drain: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        single && !tx_pin_oe_n_out |-> !tx_pin_out) else $error("single-wire pin driven high");
    a_sync_no_start: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        $rose(tx_state_reg == TX_START) |-> !$past(sync_mode)) else $error("start bit in sync mode");
    a_ack_one: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        ack_reg |=> !ack_reg) else $error("ack held two cycles");
endmodule // uart_sw_core

/* File: rtl/uart_sw_map.svh */
`ifndef UART_SW_MAP_SVH
`define UART_SW_MAP_SVH
// What this block does
// - Ratio 00: sixteen samples per bit, rate = clock/(int*16 + frac).
// - Ratio 01: eight samples per bit, rate = clock/(int*8).
// - Ratio 10: four samples per bit, rate = clock/(int*4).
// - Ratio 11: dedicated sampling, rate = clock*256/int.
// - A non-zero fraction forces sixteen samples per bit.
// - Start select 0 finds a falling edge, 1 finds a low level.
// - Mode bit clear is asynchronous framing, set is clocked synchronous operation.
// - Stop field: 00 one, 01 one and a half, 10 two, 11 reserved.
// - Check field: none, user ninth bit, even parity, odd parity.
// - Eight data bits without a check option, nine bits with any in asynchronous mode; clocked mode always uses eight.
// - Control bit 1 enables receive, bit 0 enables transmit.
// - Writing zero to the flag-clear register clears every flag at once.
// - Single-wire receive runs with both circuits enabled, frames arrive on shared pin.
// - Receive-done sets after each frame with check and framing errors valid.
// - Writing zero at receive-done position of flag-clear clears receive-done.
// - Single-wire uses the transmit pin both ways, otherwise separate pins.
`define OFS_CONTROL_ONE 6'h00
`define OFS_CONTROL_TWO 6'h04
`define OFS_EVENT_ENABLE 6'h08
`define OFS_RATE_INT 6'h0C
`define OFS_RATE_FRAC 6'h10
`define OFS_EVENT_FLAGS 6'h1C
`define OFS_FLAG_CLEAR 6'h20
`define OFS_RECEIVED_WORD 6'h24
`define OFS_OUTGOING_WORD 6'h28
`define OFS_OWN_ADDRESS 6'h30
`define OFS_ADDRESS_MASK 6'h34
`define CR1_RATIO_HI 10
`define CR1_RATIO_LO 9
`define CR1_START_SEL 8
`define CR1_SYNC_MODE 6
`define CR1_STOP_HI 5
`define CR1_STOP_LO 4
`define CR1_CHECK_HI 3
`define CR1_CHECK_LO 2
`define CR1_RX_ON 1
`define CR1_TX_ON 0
`define CR2_SINGLE_WIRE 1
`define FLAG_TC 1
`define FLAG_RC 2
`define FLAG_FE 3
`define FLAG_PE 4
`define RESET_CONTROL_ONE 11'h000
`define RESET_WORD 32'h00000000
`define PHASE_STEP 26'h0000100
`endif

/* File: rtl/uart_sw_pkg.sv */
package uart_sw_pkg;
    // Classic Wishbone request as seen by the slave.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [5:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;
    // Classic Wishbone answer.
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;
    // Sticky status flags, packed in their register order.
    typedef struct packed {
        logic pe;
        logic fe;
        logic rc;
        logic tc;
    } flags_t;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_t;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } tx_state_t;
endpackage
